// *** tlih_pkg.sv ***
// Package of the two-level interrupt handler: source count, vectors, timing.
// Assumes a single system clock domain shared with the processor core.
package tlih_pkg;
    // =====================================================================
    // Sources and vectors
    // =====================================================================
    localparam int unsigned NUM_SRC       = 17;
    localparam int unsigned SRC_W         = 5;
    localparam int unsigned VEC_W         = 16;
    localparam logic [15:0] VEC_BASE      = 16'h0003;
    localparam logic [15:0] VEC_STEP      = 16'h0008;
    localparam int unsigned SRC_EXT0      = 0;
    localparam int unsigned SRC_EXT1      = 2;
    localparam int unsigned GLOBAL_EN_BIT = 7;
    // =====================================================================
    // Reset values
    // =====================================================================
    localparam logic [16:0] ENABLE_RST    = 17'h00000;
    localparam logic [16:0] PRIORITY_RST  = 17'h00000;
    localparam logic        GLOBAL_EN_RST = 1'b0;
    // =====================================================================
    // Timing, in system clock cycles
    // =====================================================================
    localparam int unsigned DETECT_CYCLES = 1;
    localparam int unsigned CALL_CYCLES   = 5;
    localparam int unsigned RESPONSE_MIN  = DETECT_CYCLES + CALL_CYCLES;

    typedef enum logic [1:0] {
        ST_RUN,
        ST_CALL,
        ST_HOLD
    } tlih_state_type;
endpackage

// *** tlih_ext_if.sv ***
// Interface between the handler and one external input conditioner.
// Assumes one conditioner instance per external input.
interface tlih_ext_if;
    logic pin;
    logic edge_sel;
    logic polarity;
    logic sw_set;
    logic sw_clr;
    logic vec_clr;
    logic pending;
    modport cond (input pin, edge_sel, polarity, sw_set, sw_clr, vec_clr,
                  output pending);
    modport ctrl (output pin, edge_sel, polarity, sw_set, sw_clr, vec_clr,
                  input pending);
endinterface

// *** tlih_ext_cond.sv ***
// External input conditioner: polarity, edge or level sensing, pending flag.
// Assumes the pin is already synchronous to clk_sys_i.
module tlih_ext_cond
    import tlih_pkg::*;
(
    input  wire logic clk_sys_i,
    input  wire logic nrst_i,
    tlih_ext_if.cond  ext
);
    logic active;
    logic active_reg;
    logic active_next;
    logic flag_reg;
    logic flag_next;

    // =====================================================================
    // Sensing
    // =====================================================================
    always_comb begin
        active      = ext.polarity ? ext.pin : ~ext.pin;
        active_next = active;
        if (ext.edge_sel) begin
            flag_next = flag_reg;
            if (ext.sw_clr || ext.vec_clr) begin
                flag_next = 1'b0;
            end
            // Set wins over clear so a same-cycle edge is kept
            if ((active && !active_reg) || ext.sw_set) begin
                flag_next = 1'b1;
            end
        end else begin
            flag_next = active;
        end
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            active_reg <= 1'b0;
            flag_reg   <= 1'b0;
        end else begin
            active_reg <= active_next;
            flag_reg   <= flag_next;
        end
    end

    // Level mode shows the active level registered one cycle late, edge mode the sticky flag
    assign ext.pending = flag_reg;
endmodule

// *** tlih_top.sv ***
// Two-level interrupt handler: pending flags, masking, priority, vectoring.
// Assumes the core pulses insn_done_i at each instruction end and
// return_from_irq_done_i when a return-from-interrupt completes; call_done_i marks
// the end of the forced long call.
//
// Contract
// - A source meeting its condition sets its pending flag.
// - Pending flags set regardless of enable state.
// - Enabled pending source: finish instruction, force call to fixed vector.
// - Return-from-interrupt resumes at the instruction that would have run.
// - Pending flag without enable makes no request.
// - Per-source enables honoured only while global enable bit 7 is one.
// - Global enable zero blocks every source.
// - Only some flags auto-clear on vectoring; others wait for software.
// - Flag still set after return re-enters after one more instruction.
// - Software-set flag behaves like a hardware-set one. Level-sensed external inputs ignore sw_set_i and sw_clr_i.
// - Edge-select 1 edge, 0 level; polarity 0 low, 1 high.
// - Edge-sensed external flag clears when the core vectors to it.
// - Level-sensed external flag follows the active input level.
// - External inputs sample their pin independent of pin multiplexing.
// - High priority preempts low routine; high routines never preempted.
// - All priority bits default to low.
// - Higher level wins; fixed source order within a level.
// - Sample and decode every clock; fastest response six cycles.
// - Equal or lower request waits for return plus one instruction.
module tlih_top
    import tlih_pkg::*;
#(
    parameter int unsigned N_SRC = NUM_SRC
)
(
    input  wire logic               clk_sys_i,
    input  wire logic               nrst_i,
    input  wire logic [N_SRC-1:0]   src_event_i,
    input  wire logic [N_SRC-1:0]   sw_set_i,
    input  wire logic [N_SRC-1:0]   sw_clr_i,
    input  wire logic [N_SRC-1:0]   auto_clr_i,
    input  wire logic [N_SRC-1:0]   enable_i,
    input  wire logic [7:0]         main_irq_mask_reg_i,
    input  wire logic [N_SRC-1:0]   priority_i,
    input  wire logic               cfg_we_i,
    input  wire logic               ext_irq_input_0_i,
    input  wire logic               ext_irq_input_1_i,
    input  wire logic               ext0_edge_select_i,
    input  wire logic               ext1_edge_select_i,
    input  wire logic               ext0_polarity_i,
    input  wire logic               ext1_polarity_i,
    input  wire logic               insn_done_i,
    input  wire logic               call_done_i,
    input  wire logic               return_from_irq_done_i,
    output logic                    irq_req_o,
    output logic [VEC_W-1:0]        irq_vector_o,
    output logic [N_SRC-1:0]        pending_o,
    output logic                    in_high_o,
    output logic                    in_low_o,
    output logic                    global_irq_enable_o
);
    tlih_state_type     state_reg;
    tlih_state_type     state_next;
    logic [N_SRC-1:0]   flag_reg;
    logic [N_SRC-1:0]   flag_next;
    logic [N_SRC-1:0]   en_reg;
    logic [N_SRC-1:0]   en_next;
    logic [N_SRC-1:0]   prio_reg;
    logic [N_SRC-1:0]   prio_next;
    logic               gen_reg;
    logic               gen_next;
    logic               in_high_reg;
    logic               in_high_next;
    logic               in_low_reg;
    logic               in_low_next;
    logic               hold_reg;
    logic               hold_next;
    logic               req_reg;
    logic               req_next;
    logic [VEC_W-1:0]   vec_reg;
    logic [VEC_W-1:0]   vec_next;
    logic [SRC_W-1:0]   sel_reg;
    logic [SRC_W-1:0]   sel_next;
    logic               sel_high_reg;
    logic               sel_high_next;
    logic [N_SRC-1:0]   pend_all;
    logic [N_SRC-1:0]   armed;
    logic [N_SRC-1:0]   vec_clr;
    logic               win_valid;
    logic               win_high;
    logic [SRC_W-1:0]   win_idx;
    logic               may_take;

    tlih_ext_if ext0 ();
    tlih_ext_if ext1 ();

    // =====================================================================
    // External inputs
    // =====================================================================
    // Pins come straight in, no mux: the pad keeps serving its peripheral
    assign ext0.pin      = ext_irq_input_0_i;
    assign ext1.pin      = ext_irq_input_1_i;
    assign ext0.edge_sel = ext0_edge_select_i;
    assign ext1.edge_sel = ext1_edge_select_i;
    assign ext0.polarity = ext0_polarity_i;
    assign ext1.polarity = ext1_polarity_i;
    assign ext0.sw_set   = sw_set_i[SRC_EXT0];
    assign ext1.sw_set   = sw_set_i[SRC_EXT1];
    assign ext0.sw_clr   = sw_clr_i[SRC_EXT0];
    assign ext1.sw_clr   = sw_clr_i[SRC_EXT1];
    assign ext0.vec_clr  = vec_clr[SRC_EXT0] & ext0_edge_select_i;
    assign ext1.vec_clr  = vec_clr[SRC_EXT1] & ext1_edge_select_i;

    tlih_ext_cond u_ext0 (
        .clk_sys_i (clk_sys_i),
        .nrst_i    (nrst_i),
        .ext       (ext0)
    );

    tlih_ext_cond u_ext1 (
        .clk_sys_i (clk_sys_i),
        .nrst_i    (nrst_i),
        .ext       (ext1)
    );

    // =====================================================================
    // Pending flags
    // =====================================================================
    always_comb begin
        vec_clr = '0;
        if (state_reg == ST_CALL && call_done_i) begin
            vec_clr[sel_reg] = 1'b1;
        end
        for (int i = 0; i < N_SRC; i++) begin
            flag_next[i] = flag_reg[i];
            // Internal sources drop on vectoring only if flagged auto-clear
            if (sw_clr_i[i] || (vec_clr[i] && auto_clr_i[i])) begin
                flag_next[i] = 1'b0;
            end
            // Set after clear: an event in the clearing cycle survives
            if (src_event_i[i] || sw_set_i[i]) begin
                flag_next[i] = 1'b1;
            end
        end
        flag_next[SRC_EXT0] = 1'b0;
        flag_next[SRC_EXT1] = 1'b0;
        pend_all           = flag_reg;
        pend_all[SRC_EXT0] = ext0.pending;
        pend_all[SRC_EXT1] = ext1.pending;
    end

    // Pending port lags the internal flags by one cycle
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            flag_reg  <= '0;
            pending_o <= '0;
        end else begin
            flag_reg  <= flag_next;
            pending_o <= pend_all;
        end
    end

    // =====================================================================
    // Configuration
    // =====================================================================
    always_comb begin
        en_next   = en_reg;
        prio_next = prio_reg;
        gen_next  = gen_reg;
        // One strobe loads all three, so no mixed mask is ever seen
        if (cfg_we_i) begin
            en_next   = enable_i;
            prio_next = priority_i;
            gen_next  = main_irq_mask_reg_i[GLOBAL_EN_BIT];
        end
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            en_reg   <= ENABLE_RST;
            prio_reg <= PRIORITY_RST;
            gen_reg  <= GLOBAL_EN_RST;
        end else begin
            en_reg   <= en_next;
            prio_reg <= prio_next;
            gen_reg  <= gen_next;
        end
    end

    // =====================================================================
    // Priority decode, every clock
    // =====================================================================
    always_comb begin
        armed     = gen_reg ? (pend_all & en_reg) : '0;
        win_valid = 1'b0;
        win_high  = 1'b0;
        win_idx   = '0;
        // Descending scan so the lowest index wins within a level
        for (int i = N_SRC - 1; i >= 0; i--) begin
            if (armed[i] && prio_reg[i]) begin
                win_valid = 1'b1;
                win_high  = 1'b1;
                win_idx   = SRC_W'(i);
            end
        end
        if (!win_valid) begin
            for (int i = N_SRC - 1; i >= 0; i--) begin
                if (armed[i]) begin
                    win_valid = 1'b1;
                    win_idx   = SRC_W'(i);
                end
            end
        end
        // High never preempted; low only preempted by high
        // The return is no instruction; the next instruction end may re-enter
        may_take = win_valid && !in_high_reg && (!hold_reg || insn_done_i) &&
                   (win_high || !in_low_reg);
    end

    // =====================================================================
    // Vectoring sequence
    // =====================================================================
    always_comb begin
        state_next    = state_reg;
        req_next      = req_reg;
        vec_next      = vec_reg;
        sel_next      = sel_reg;
        sel_high_next = sel_high_reg;
        in_high_next  = in_high_reg;
        in_low_next   = in_low_reg;
        hold_next     = hold_reg;
        if (return_from_irq_done_i) begin
            // Returns unwind the innermost active level first
            if (in_high_reg) begin
                in_high_next = 1'b0;
            end else begin
                in_low_next = 1'b0;
            end
            hold_next = 1'b1;
        end else if (hold_reg && insn_done_i) begin
            hold_next = 1'b0;
        end
        case (state_reg)
            ST_RUN: begin
                if (may_take && insn_done_i && !return_from_irq_done_i) begin
                    req_next      = 1'b1;
                    sel_next      = win_idx;
                    sel_high_next = win_high;
                    // Base plus index times step: no vector table to keep in sync
                    vec_next      = VEC_BASE + VEC_W'({11'h000, win_idx}) * VEC_STEP;
                    state_next    = ST_CALL;
                end
            end
            ST_CALL: begin
                if (call_done_i) begin
                    req_next   = 1'b0;
                    state_next = ST_RUN;
                    if (sel_high_reg) begin
                        in_high_next = 1'b1;
                    end else begin
                        in_low_next = 1'b1;
                    end
                end
            end
            default: begin
                state_next = ST_RUN;
                req_next   = 1'b0;
            end
        endcase
    end

    // Vector and index are held for the whole forced call
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_reg    <= ST_RUN;
            in_high_reg  <= 1'b0;
            in_low_reg   <= 1'b0;
            hold_reg     <= 1'b0;
            req_reg      <= 1'b0;
            vec_reg      <= '0;
            sel_reg      <= '0;
            sel_high_reg <= 1'b0;
        end else begin
            state_reg    <= state_next;
            in_high_reg  <= in_high_next;
            in_low_reg   <= in_low_next;
            hold_reg     <= hold_next;
            req_reg      <= req_next;
            vec_reg      <= vec_next;
            sel_reg      <= sel_next;
            sel_high_reg <= sel_high_next;
        end
    end

    // =====================================================================
    // Outputs
    // =====================================================================
    // Each output is a register, so the core sees no decode glitches
    assign irq_req_o           = req_reg;
    assign irq_vector_o        = vec_reg;
    assign in_high_o           = in_high_reg;
    assign in_low_o            = in_low_reg;
    assign global_irq_enable_o = gen_reg;
endmodule

// *** tlih_props.sv ***
// Port checker for the two-level interrupt handler.
// Assumes it is bound onto tlih_top with one system clock.
module tlih_chk
    import tlih_pkg::*;
#(
    parameter int unsigned N_SRC = NUM_SRC
)
(
    input wire logic             clk_sys_i,
    input wire logic             nrst_i,
    input wire logic [N_SRC-1:0] src_event_i,
    input wire logic [N_SRC-1:0] auto_clr_i,
    input wire logic             cfg_we_i,
    input wire logic             ext_irq_input_0_i,
    input wire logic             ext0_edge_select_i,
    input wire logic             ext0_polarity_i,
    input wire logic             insn_done_i,
    input wire logic             call_done_i,
    input wire logic             return_from_irq_done_i,
    input wire logic             irq_req_o,
    input wire logic [VEC_W-1:0] irq_vector_o,
    input wire logic [N_SRC-1:0] pending_o,
    input wire logic             in_high_o,
    input wire logic             in_low_o,
    input wire logic             global_irq_enable_o
);
    // ==========
    // Sequences
    // ==========
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);
    sequence s_taken; $rose(irq_req_o); endsequence
    sequence s_call_end; irq_req_o && call_done_i; endsequence
    // ==========
    // Assertions
    // ==========
    req_after_insn_a: assert property (
        s_taken |-> $past(insn_done_i) && !$past(return_from_irq_done_i))
        else $error("request not launched by a plain instruction end");
    req_hold_a: assert property (
        irq_req_o && !call_done_i |=> irq_req_o && $stable(irq_vector_o))
        else $error("request or vector moved before the call ended");
    req_drop_a: assert property (
        s_call_end |=> !irq_req_o && (in_high_o || in_low_o))
        else $error("call end did not enter a routine");
    global_block_a: assert property (
        !global_irq_enable_o && !cfg_we_i && !$past(cfg_we_i) && !irq_req_o |=> !irq_req_o)
        else $error("request while globally disabled");
    no_preempt_a: assert property (
        s_taken |-> !$past(in_high_o))
        else $error("high routine was preempted");
    flag_set_a: assert property (
        src_event_i[1] && !auto_clr_i[1] |-> ##[1:2] pending_o[1])
        else $error("source event left its flag clear");
    level_follow_a: assert property (
        (!ext0_edge_select_i && $stable(ext_irq_input_0_i) && $stable(ext0_polarity_i))[*4]
        |-> pending_o[SRC_EXT0] == (ext_irq_input_0_i == ext0_polarity_i))
        else $error("level flag does not follow the pin");
    reset_clear_a: assert property (
        $rose(nrst_i) |-> !irq_req_o && !in_high_o && !in_low_o && !global_irq_enable_o)
        else $error("state not cleared by reset");
endmodule

bind tlih_top tlih_chk #(.N_SRC(N_SRC)) u_chk (.clk_sys_i, .nrst_i, .src_event_i,
    .auto_clr_i, .cfg_we_i, .ext_irq_input_0_i, .ext0_edge_select_i, .ext0_polarity_i,
    .insn_done_i, .call_done_i, .return_from_irq_done_i, .irq_req_o, .irq_vector_o, .pending_o,
    .in_high_o, .in_low_o, .global_irq_enable_o);

// *** tlih_core_model.sv ***
// Behavioural processor core: paces instructions, runs the forced call.
// Assumes the handler samples on the rising edge of clk_sys_i.
module tlih_core_model (
    input  wire logic clk_sys_i,
    input  wire logic nrst_i,
    input  wire logic irq_req_i,
    input  wire logic run_i,
    input  wire logic return_from_irq_cmd_i,
    output logic      insn_done_o,
    output logic      call_done_o,
    output logic      return_from_irq_done_o
);
    timeunit 1ns;
    timeprecision 1ns;
    int unsigned call_cnt;
    // Changes just after the rising edge; run_i low stalls instructions
    always @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            call_cnt    <= 0;
            insn_done_o <= 1'b0;
            call_done_o <= 1'b0;
            return_from_irq_done_o <= 1'b0;
        end else begin
            insn_done_o <= 1'b0;
            return_from_irq_done_o <= 1'b0;
            if (irq_req_i) begin
                call_cnt    <= call_cnt + 1;
                call_done_o <= (call_cnt == 2);
            end else begin
                call_cnt    <= 0;
                call_done_o <= 1'b0;
                return_from_irq_done_o <= return_from_irq_cmd_i;
                insn_done_o <= run_i && !return_from_irq_cmd_i && !insn_done_o;
            end
        end
    end
endmodule

// *** tb_two_level_interrupt_handler.sv ***
// Self-checking bench of the interrupt handler against a core model.
// Assumes tlih_top, tlih_core_model and the bound checker are compiled.
module tb_two_level_interrupt_handler;
    import tlih_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic [NUM_SRC-1:0] ev = '0, sset = '0, sclr = '0, aclr = '0, en = '0, pri = '0;
    logic [NUM_SRC-1:0] pend, m, pr;
    logic [7:0]         gmask = 8'h00;
    logic [VEC_W-1:0]   vec;
    logic [VEC_W-1:0]   exp_q[$];
    logic clk_sys_i = 1'b0, nrst_i = 1'b0, we = 1'b0, run = 1'b1, return_from_irq = 1'b0, req_d = 1'b0;
    logic p0 = 1'b0, p1 = 1'b0, es0 = 1'b1, es1 = 1'b1, pl0 = 1'b1, pl1 = 1'b1;
    logic insn, call, rdone, req, hi, lo, ge;
    int   err_count = 0, checks = 0, cyc = 0, w, n_insn = 0, ret_insn = 0;
    initial forever #25 clk_sys_i = ~clk_sys_i;
    tlih_top u_dut (.clk_sys_i, .nrst_i, .src_event_i(ev), .sw_set_i(sset), .sw_clr_i(sclr),
        .auto_clr_i(aclr), .enable_i(en), .main_irq_mask_reg_i(gmask), .priority_i(pri),
        .cfg_we_i(we), .ext_irq_input_0_i(p0), .ext_irq_input_1_i(p1),
        .ext0_edge_select_i(es0), .ext1_edge_select_i(es1), .ext0_polarity_i(pl0),
        .ext1_polarity_i(pl1), .insn_done_i(insn), .call_done_i(call), .return_from_irq_done_i(rdone),
        .irq_req_o(req), .irq_vector_o(vec), .pending_o(pend), .in_high_o(hi),
        .in_low_o(lo), .global_irq_enable_o(ge));
    tlih_core_model u_core (.clk_sys_i, .nrst_i, .irq_req_i(req), .run_i(run),
        .return_from_irq_cmd_i(return_from_irq), .insn_done_o(insn), .call_done_o(call), .return_from_irq_done_o(rdone));
    // ==========
    // Tasks
    // ==========
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clk_sys_i);
    endtask
    task automatic cfg(input logic [NUM_SRC-1:0] e, p, input logic g);
        en = e; pri = p; gmask = {g, 7'h00}; we = 1'b1;
        tick(1); we = 1'b0;
    endtask
    task automatic pend_op(input logic [NUM_SRC-1:0] s, c);
        sset = s; sclr = c;
        tick(1); sset = '0; sclr = '0;
    endtask
    task automatic leave();
        return_from_irq = 1'b1;
        tick(1); return_from_irq = 1'b0; tick(1);
    endtask
    // Note the vector first, so the watcher already holds it when the request rises
    task automatic serve(input int src, input bit with_ret);
        exp_q.push_back(16'(VEC_BASE + VEC_STEP * src));
        if (with_ret) leave();
        for (int i = 0; i < 60 && !(call === 1'b1 && req === 1'b1); i++) tick(1);
        tick(2);
        if (with_ret) chk("insns after return", 1, ret_insn);
    endtask
    task automatic done_test(input string n);
        chk("leftover requests", 0, exp_q.size());
        $display("test %s done", n);
    endtask
    function automatic int winner(input logic [NUM_SRC-1:0] s, p);
        for (int i = 0; i < NUM_SRC; i++) if (s[i] && p[i]) return i;
        for (int i = 0; i < NUM_SRC; i++) if (s[i]) return i;
        return 0;
    endfunction
    always @(negedge clk_sys_i) begin
        if (req === 1'b1 && req_d !== 1'b1) begin
            ret_insn = n_insn;
            if (exp_q.size() == 0) chk("unexpected request", 0, 1);
            else chk("vector", exp_q.pop_front(), vec);
        end
        req_d <= req;
    end
    always @(posedge clk_sys_i) begin
        cyc++;
        if (rdone === 1'b1) n_insn = 0;
        else if (insn === 1'b1) n_insn++;
        if (cyc == 20000) begin
            err_count++;
            give_verdict();
        end
    end
    // ==========
    // Tests
    // ==========
    initial begin
        void'($urandom(32'hBD42C302));
        tick(6); nrst_i = 1'b1; tick(2);
        chk("reset state", 0, {ge, hi, lo, req, pend});
        cfg('1, '0, 1'b0);
        ev[1] = 1'b1; tick(1); ev = '0; tick(20);
        chk("flag while masked", 1, pend[1]);
        cfg('0, '0, 1'b1); tick(20);
        chk("global enable", 1, ge);
        cfg(17'h00002, '0, 1'b1); serve(1, 0);
        chk("flag kept", 1, pend[1]);
        serve(1, 1);
        pend_op('0, '1); leave(); done_test("masking");
        for (int k = 0; k < 12; k++) begin
            m = 17'($urandom) | (17'h1 << (k % NUM_SRC)); pr = 17'($urandom); aclr = 17'($urandom);
            run = 1'b0; cfg('1, pr, 1'b1); pend_op(m, '0); tick(2);
            chk("software flags", m, pend);
            w = winner(m, pr); run = 1'b1; serve(w, 0);
            chk("auto clear", (w == 0 || w == 2) ? 0 : !aclr[w], pend[w]);
            pend_op('0, '1); leave();
        end
        aclr = '0; done_test("arbitration");
        cfg('1, 17'h00060, 1'b1); pend_op(17'h00008, '0); serve(3, 0);
        pend_op(17'h00010, '0); tick(20);
        pend_op(17'h00020, '0); serve(5, 0); chk("in high", 1, hi);
        pend_op(17'h00040, '0); tick(20);
        pend_op('0, '1); leave(); leave(); tick(3);
        chk("idle", 0, {hi, lo}); done_test("nesting");
        for (int i = 0; i < 8; i++) begin
            cfg(17'h00005, '0, 1'b0);
            es0 = i[1]; es1 = i[1]; pl0 = i[2]; pl1 = i[2]; p0 = !i[2]; p1 = !i[2];
            tick(4); pend_op('0, '1); tick(3); cfg(17'h00005, '0, 1'b1);
            // Only one input goes active, the other stays idle
            w = i[0] ? SRC_EXT1 : SRC_EXT0;
            if (i[0]) p1 = i[2];
            else p0 = i[2];
            serve(w, 0);
            if (!i[1]) chk("level flag", 1, pend[w]);
            p0 = !i[2]; p1 = !i[2]; tick(4);
            chk("ext flag", 0, pend[w]);
            leave();
        end
        done_test("external");
        give_verdict();
    end
endmodule
